// >>> inpc_defs.svh
/*
  Shared constants of the interrupt nesting and priority block: register
  offsets, field positions, reset values and sizes.
  Assumes it is included by bare name from the package and from design files.
*/
`ifndef INPC_DEFS_SVH
`define INPC_DEFS_SVH

// ==========================================================================
// device register offsets (byte addresses on the core bus)
`define INPC_NORMAL_EN_ADDR 32'hFFFF0008
`define INPC_VEC_BASE_ADDR 32'hFFFF0014
`define INPC_NORMAL_VEC_ADDR 32'hFFFF001C
`define INPC_PRIO0_ADDR 32'hFFFF0020
`define INPC_NEST_CTL_ADDR 32'hFFFF0030
`define INPC_TRIG_CFG_ADDR 32'hFFFF0034
`define INPC_EDGE_CLR_ADDR 32'hFFFF0038
`define INPC_NORMAL_ISR_ADDR 32'hFFFF003C
`define INPC_FAST_EN_ADDR 32'hFFFF0108
`define INPC_FAST_VEC_ADDR 32'hFFFF011C
`define INPC_FAST_ISR_ADDR 32'hFFFF013C

// ==========================================================================
// reset values
`define INPC_NEST_CTL_RST 2'h0
`define INPC_ISR_RST 8'h00

// ==========================================================================
// field positions and sizes
`define INPC_NORMAL_NEST_BIT 0
`define INPC_FAST_NEST_BIT 1
`define INPC_NUM_SRC 28
`define INPC_NUM_EXT 6
`define INPC_EXT_SRC_BASE 17
`define INPC_CLR_LO_BASE 19
`define INPC_CLR_HI_BASE 20
`define INPC_PRIO_FIELD_W 4
`define INPC_PRIO_PER_WORD 8

// ==========================================================================
// host command registers (byte offsets on the wishbone side)
`define INPC_HOST_ADDR_OFS 8'h00
`define INPC_HOST_WDATA_OFS 8'h04
`define INPC_HOST_CTRL_OFS 8'h08
`define INPC_HOST_STATUS_OFS 8'h0C
`define INPC_HOST_RDATA_OFS 8'h10
`define INPC_CTRL_GO_BIT 0
`define INPC_CTRL_WE_BIT 1
`define INPC_STAT_BUSY_BIT 0
`define INPC_STAT_IRQ_BIT 1
`define INPC_STAT_FIQ_BIT 2

`endif

// >>> inpc_pkg.sv
/*
  Types shared by both ends of the interrupt nesting and priority block.
  Assumes inpc_defs.svh is on the include path.
*/
`include "inpc_defs.svh"

package inpc_pkg;

  // ========================================================================
  // plain vectors
  typedef logic [31:0] inpc_word_t;
  typedef logic [`INPC_NUM_SRC-1:0] inpc_src_t;
  typedef logic [`INPC_NUM_EXT-1:0] inpc_ext_t;

  // ========================================================================
  // trigger selector codes of one external line
  typedef enum logic [1:0] {
    INPC_TRIG_HIGH = 2'h0,
    INPC_TRIG_LOW = 2'h1,
    INPC_TRIG_RISE = 2'h2,
    INPC_TRIG_FALL = 2'h3
  } inpc_trig_t;

  // result of one arbitration pass
  typedef struct packed {
    logic hit;
    logic [4:0] src;
    logic [2:0] lvl;
  } inpc_pick_t;

  // host bus sequencer
  typedef enum logic [1:0] {
    INPC_HOST_IDLE = 2'h1,
    INPC_HOST_WAIT = 2'h2
  } inpc_host_state_t;

endpackage

// >>> inpc_if.sv
/*
  Register bus and interrupt lines between the interrupt controller and
  the processor core that services it.
  Assumes both ends share sys_clk; the ends drive every signal from flops.
*/
`timescale 1ns/1ps
`default_nettype none

interface inpc_if;
  // request, held by the core until ack
  logic req;
  logic we;
  logic [31:0] addr;
  logic [31:0] wdata;
  // answer
  logic [31:0] rdata;
  logic ack;
  // interrupt lines to the core
  logic irq;
  logic fiq;

  modport dev (
    input req,
    input we,
    input addr,
    input wdata,
    output rdata,
    output ack,
    output irq,
    output fiq
  );

  modport core (
    output req,
    output we,
    output addr,
    output wdata,
    input rdata,
    input ack,
    input irq,
    input fiq
  );
endinterface

`default_nettype wire

// >>> inpc_ext_line.sv
/*
  One external interrupt line: level pass-through or sticky edge latch.
  Assumes the pin is already synchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module inpc_ext_line (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // pin and configuration
  input wire logic pin,
  input wire inpc_pkg::inpc_trig_t trig_sel,
  input wire logic edge_clr,
  // request to the arbiter
  output logic req
);
  import inpc_pkg::*;

  logic pin_q;
  logic latched;
  logic edge_hit;

  // ========================================================================
  // previous pin level for edge detection
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin;
    end
  end

  // edge seen in the selected direction
  assign edge_hit = ((trig_sel == INPC_TRIG_RISE) && pin && !pin_q) ||
                    ((trig_sel == INPC_TRIG_FALL) && !pin && pin_q); // R13

  // sticky latch; a fresh edge beats a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      latched <= 1'b0;
    end else if (edge_hit) begin
      latched <= 1'b1; // R10
    end else if (edge_clr) begin
      latched <= 1'b0; // R12
    end
  end

  // level modes follow the pin directly, so they need no clear
  always_comb begin
    unique case (trig_sel)
      INPC_TRIG_HIGH: req = pin; // R13
      INPC_TRIG_LOW: req = !pin; // R13
      default: req = latched; // R12
    endcase
  end
endmodule

`default_nettype wire

// >>> inpc_device.sv
/*
  Interrupt controller end: source enables, per-source priority levels,
  nesting control, in-service status, vectors and six external lines.
  Assumes a core that holds each bus request until ack and releases it
  at the ack edge; all source and pin inputs are synchronous to sys_clk.

// Operation
// [R1] nest enables: bit0 normal, bit1 fast, zero reset
// [R2] nesting off: no priorities, fast beats normal
// [R3] normal vector read sets normal in-service bit
// [R4] fast vector read sets fast in-service bit
// [R5] in-service bit blocks same and lower priority
// [R6] status write clears only lowest set bit
// [R7] fast vector: zero, base, source, zero fields
// [R8] software reads fast vector only while servicing
// [R9] software leaves reserved upper bits unwritten
// [R10] six external lines, level or edge triggered
// [R11] software enables line and programs its trigger
// [R12] edge request stays latched until edge clear
// [R13] selector codes: fall, rise, low, high
// [R14] three-bit priority level per source
// [R15] status reads harmless; empty clear stays zero
*/
`timescale 1ns/1ps
`default_nettype none
`include "inpc_defs.svh"

module inpc_device (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // core bus and interrupt lines
  inpc_if.dev core,
  // peripheral requests and external pins
  input wire inpc_pkg::inpc_src_t src_req,
  input wire inpc_pkg::inpc_ext_t ext_pin
);
  import inpc_pkg::*;

  // ========================================================================
  // state and wires
  logic [1:0] nest_ctl;
  logic [7:0] normal_isr;
  logic [7:0] fast_isr;
  logic [15:0] vector_base;
  inpc_src_t normal_en;
  inpc_src_t fast_en;
  logic [2:0] prio_lvl [0:`INPC_NUM_SRC-1];
  logic [2*`INPC_NUM_EXT-1:0] trig_cfg;
  inpc_ext_t ext_req;
  inpc_ext_t ext_clr;
  inpc_src_t raw_req;
  logic [3*`INPC_NUM_SRC-1:0] prio_flat;
  inpc_pick_t normal_pick;
  inpc_pick_t fast_pick;
  logic take;
  logic wr;
  logic rd;
  logic prio_hit;
  inpc_word_t next_rdata;

  // ========================================================================
  // helpers
  // index of lowest set bit, 8 when none
  function automatic logic [3:0] lowest_set(input logic [7:0] v);
    logic [3:0] idx;
    idx = 4'h8;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  // drop the highest-priority bit only; zero stays zero
  function automatic logic [7:0] clear_top(input logic [7:0] v);
    return v & (v - 8'h01);
  endfunction

  // vector word: zero top, base, source number, zero bottom
  function automatic inpc_word_t make_vector(input logic [15:0] base,
                                             input logic [4:0] src);
    return {9'h000, base, src, 2'h0};
  endfunction

  // pick the winner among pending sources of one type
  function automatic inpc_pick_t pick_source(input inpc_src_t pend,
                                             input logic [3*`INPC_NUM_SRC-1:0] lvls,
                                             input logic nest,
                                             input logic [3:0] limit);
    inpc_pick_t p;
    logic [2:0] lv;
    p = '0;
    lv = 3'h0;
    // walk downward so ties go to the lowest source number
    for (int i = `INPC_NUM_SRC - 1; i >= 0; i--) begin
      lv = lvls[3*i +: 3];
      if (pend[i] && (!nest || ({1'b0, lv} < limit)) &&
          (!nest || !p.hit || lv <= p.lvl)) begin
        p.hit = 1'b1;
        p.src = 5'(i);
        p.lvl = lv;
      end
    end
    return p;
  endfunction

  // edge clear bit of external line k (bit 23 is skipped)
  function automatic int clr_bit(input int k);
    return (k < 4) ? (`INPC_CLR_LO_BASE + k) : (`INPC_CLR_HI_BASE + k);
  endfunction

  // ========================================================================
  // bus decode: one take per request, answered next cycle
  assign take = core.req && !core.ack;
  assign wr = take && core.we;
  assign rd = take && !core.we;
  assign prio_hit = (core.addr[31:4] == 28'(`INPC_PRIO0_ADDR >> 4));

  // ========================================================================
  // external lines
  for (genvar g = 0; g < `INPC_NUM_EXT; g++) begin : g_ext
    assign ext_clr[g] = wr && (core.addr == `INPC_EDGE_CLR_ADDR) &&
                        core.wdata[clr_bit(g)]; // R12
    inpc_ext_line u_line (
      .sys_clk(sys_clk),
      .rst(rst),
      .pin(ext_pin[g]),
      .trig_sel(inpc_trig_t'(trig_cfg[2*g +: 2])),
      .edge_clr(ext_clr[g]),
      .req(ext_req[g])
    );
  end

  // external lines take over their source slots
  always_comb begin
    raw_req = src_req;
    for (int k = 0; k < `INPC_NUM_EXT; k++) begin
      raw_req[`INPC_EXT_SRC_BASE + k] = ext_req[k]; // R10
    end
    for (int s = 0; s < `INPC_NUM_SRC; s++) begin
      prio_flat[3*s +: 3] = prio_lvl[s];
    end
  end

  // ========================================================================
  // arbitration; in-service bits set the blocking limit
  assign normal_pick = pick_source(raw_req & normal_en, prio_flat,
                                   nest_ctl[`INPC_NORMAL_NEST_BIT],
                                   lowest_set(normal_isr)); // R5 R2
  assign fast_pick = pick_source(raw_req & fast_en, prio_flat,
                                 nest_ctl[`INPC_FAST_NEST_BIT],
                                 lowest_set(fast_isr)); // R5 R2

  // interrupt lines; without normal nesting a fast request masks normal
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      core.irq <= 1'b0;
      core.fiq <= 1'b0;
    end else begin
      core.fiq <= fast_pick.hit;
      core.irq <= normal_pick.hit &&
                  (nest_ctl[`INPC_NORMAL_NEST_BIT] || !fast_pick.hit); // R2
    end
  end

  // ========================================================================
  // control registers; reserved bits are dropped on write
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      nest_ctl <= `INPC_NEST_CTL_RST; // R1
      vector_base <= 16'h0000;
      normal_en <= '0;
      fast_en <= '0;
      trig_cfg <= '0;
    end else if (wr) begin
      case (core.addr)
        `INPC_NEST_CTL_ADDR: nest_ctl <= core.wdata[1:0]; // R1
        `INPC_VEC_BASE_ADDR: vector_base <= core.wdata[15:0];
        `INPC_NORMAL_EN_ADDR: normal_en <= core.wdata[`INPC_NUM_SRC-1:0];
        `INPC_FAST_EN_ADDR: fast_en <= core.wdata[`INPC_NUM_SRC-1:0];
        `INPC_TRIG_CFG_ADDR: trig_cfg <= core.wdata[2*`INPC_NUM_EXT-1:0]; // R13
        default: begin
        end
      endcase
    end
  end

  // priority fields, one nibble per source, eight to a word
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int s = 0; s < `INPC_NUM_SRC; s++) begin
        prio_lvl[s] <= 3'h0;
      end
    end else if (wr && prio_hit) begin
      for (int j = 0; j < `INPC_PRIO_PER_WORD; j++) begin
        if (32'(core.addr[3:2]) * `INPC_PRIO_PER_WORD + j < `INPC_NUM_SRC) begin
          prio_lvl[32'(core.addr[3:2]) * `INPC_PRIO_PER_WORD + j] <=
            core.wdata[`INPC_PRIO_FIELD_W*j +: 3]; // R14
        end
      end
    end
  end

  // ========================================================================
  // normal in-service status: vector read sets, any write clears one
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      normal_isr <= `INPC_ISR_RST;
    end else if (rd && core.addr == `INPC_NORMAL_VEC_ADDR &&
                 nest_ctl[`INPC_NORMAL_NEST_BIT] && normal_pick.hit) begin
      normal_isr <= normal_isr | (8'h01 << normal_pick.lvl); // R3
    end else if (wr && core.addr == `INPC_NORMAL_ISR_ADDR) begin
      normal_isr <= clear_top(normal_isr); // R6 R15
    end
  end

  // fast in-service status, same scheme
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fast_isr <= `INPC_ISR_RST;
    end else if (rd && core.addr == `INPC_FAST_VEC_ADDR &&
                 nest_ctl[`INPC_FAST_NEST_BIT] && fast_pick.hit) begin
      fast_isr <= fast_isr | (8'h01 << fast_pick.lvl); // R4
    end else if (wr && core.addr == `INPC_FAST_ISR_ADDR) begin
      fast_isr <= clear_top(fast_isr); // R6 R15
    end
  end

  // ========================================================================
  // read mux; unmapped and write-only addresses read zero
  always_comb begin
    next_rdata = 32'h00000000;
    if (prio_hit) begin
      for (int j = 0; j < `INPC_PRIO_PER_WORD; j++) begin
        if (32'(core.addr[3:2]) * `INPC_PRIO_PER_WORD + j < `INPC_NUM_SRC) begin
          next_rdata[`INPC_PRIO_FIELD_W*j +: 3] =
            prio_lvl[32'(core.addr[3:2]) * `INPC_PRIO_PER_WORD + j]; // R14
        end
      end
    end else begin
      case (core.addr)
        `INPC_NEST_CTL_ADDR: next_rdata = {30'h00000000, nest_ctl};
        `INPC_VEC_BASE_ADDR: next_rdata = {16'h0000, vector_base};
        `INPC_NORMAL_EN_ADDR: next_rdata = {4'h0, normal_en};
        `INPC_FAST_EN_ADDR: next_rdata = {4'h0, fast_en};
        `INPC_TRIG_CFG_ADDR: next_rdata = {20'h00000, trig_cfg};
        `INPC_NORMAL_ISR_ADDR: next_rdata = {24'h000000, normal_isr}; // R15
        `INPC_FAST_ISR_ADDR: next_rdata = {24'h000000, fast_isr}; // R15
        `INPC_NORMAL_VEC_ADDR: next_rdata = make_vector(vector_base, normal_pick.src);
        `INPC_FAST_VEC_ADDR: next_rdata = make_vector(vector_base, fast_pick.src); // R7
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  // answer one cycle after the take; ack falls while req is released
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      core.ack <= 1'b0;
      core.rdata <= 32'h00000000;
    end else begin
      core.ack <= take;
      if (rd) begin
        core.rdata <= next_rdata;
      end
    end
  end
endmodule

`default_nettype wire

// >>> inpc_host.sv
/*
  Core end: a small bus sequencer that software drives over classic
  wishbone; it issues single reads or writes to the controller and shows
  the interrupt lines in a status register.
  Assumes the controller answers every request with one ack.
*/
`timescale 1ns/1ps
`default_nettype none
`include "inpc_defs.svh"

module inpc_host (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire inpc_pkg::inpc_word_t wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output inpc_pkg::inpc_word_t wb_dat_o,
  output logic wb_ack_o,
  // controller side
  inpc_if.core core
);
  import inpc_pkg::*;

  inpc_host_state_t state;
  inpc_word_t cmd_addr;
  inpc_word_t cmd_wdata;
  inpc_word_t rdata;
  logic wb_take;
  logic go;

  // merge a write under byte enables
  function automatic inpc_word_t apply_sel(input inpc_word_t old,
                                           input inpc_word_t nw,
                                           input logic [3:0] sel);
    inpc_word_t r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ========================================================================
  // wishbone decode; go is ignored while a transfer is in flight
  assign wb_take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign go = wb_take && wb_we_i && (wb_adr_i == `INPC_HOST_CTRL_OFS) &&
              wb_sel_i[0] && wb_dat_i[`INPC_CTRL_GO_BIT] && (state == INPC_HOST_IDLE);

  // command staging registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cmd_addr <= 32'h00000000;
      cmd_wdata <= 32'h00000000;
    end else if (wb_take && wb_we_i) begin
      if (wb_adr_i == `INPC_HOST_ADDR_OFS) begin
        cmd_addr <= apply_sel(cmd_addr, wb_dat_i, wb_sel_i);
      end
      if (wb_adr_i == `INPC_HOST_WDATA_OFS) begin
        cmd_wdata <= apply_sel(cmd_wdata, wb_dat_i, wb_sel_i);
      end
    end
  end

  // wishbone answer: one wait state, unmapped reads return zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_take;
      case (wb_adr_i)
        `INPC_HOST_ADDR_OFS: wb_dat_o <= cmd_addr;
        `INPC_HOST_WDATA_OFS: wb_dat_o <= cmd_wdata;
        `INPC_HOST_RDATA_OFS: wb_dat_o <= rdata;
        `INPC_HOST_STATUS_OFS: wb_dat_o <= {29'h00000000, core.fiq, core.irq,
                                            state == INPC_HOST_WAIT};
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  // ========================================================================
  // controller bus sequencer: request held until ack, released at it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= INPC_HOST_IDLE;
      core.req <= 1'b0;
      core.we <= 1'b0;
      core.addr <= 32'h00000000;
      core.wdata <= 32'h00000000;
      rdata <= 32'h00000000;
    end else begin
      unique case (state)
        INPC_HOST_IDLE: begin
          if (go) begin
            core.req <= 1'b1;
            core.we <= wb_dat_i[`INPC_CTRL_WE_BIT];
            core.addr <= cmd_addr;
            core.wdata <= cmd_wdata;
            state <= INPC_HOST_WAIT;
          end
        end
        INPC_HOST_WAIT: begin
          if (core.ack) begin
            core.req <= 1'b0;
            if (!core.we) begin
              rdata <= core.rdata; // R8
            end
            state <= INPC_HOST_IDLE;
          end
        end
        default: state <= INPC_HOST_IDLE;
      endcase
    end
  end
endmodule

`default_nettype wire

// >>> inpc_chk.sv
/*
  Checker of the core bus and interrupt lines between both ends.
  Assumes it sits beside the interface and sees its signals only.
*/
`timescale 1ns/1ps
`default_nettype none
`include "inpc_defs.svh"

module inpc_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // core bus
  input wire logic req,
  input wire logic we,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic ack,
  // interrupt lines
  input wire logic irq,
  input wire logic fiq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ==========================================================================
  // decode of the completing access
  logic rd, isr, isr_f, vec;
  logic [1:0] nest, known;
  logic [15:0] base, shadow;
  logic [7:0] cur;
  assign rd = ack && !we;
  assign isr_f = addr == `INPC_FAST_ISR_ADDR;
  assign isr = isr_f || addr == `INPC_NORMAL_ISR_ADDR;
  assign vec = addr == `INPC_FAST_VEC_ADDR || addr == `INPC_NORMAL_VEC_ADDR;
  assign cur = shadow[{isr_f, 3'h0} +: 8];

  // config shadows, taken from completed writes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      nest <= 2'h0;
      base <= 16'h0;
    end else if (ack && we) begin
      if (addr == `INPC_NEST_CTL_ADDR) nest <= wdata[1:0];
      if (addr == `INPC_VEC_BASE_ADDR) base <= wdata[15:0];
    end
  end

  // status shadow; a vector read sets a bit we cannot name, so trust it after a read
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      shadow <= 16'h0;
      known <= 2'h3;
    end else if (ack && isr) begin
      shadow[{isr_f, 3'h0} +: 8] <= we ? cur & (cur - 8'h1) : rdata[7:0];
      known[isr_f] <= known[isr_f] | !we;
    end else if (rd && vec) begin
      known[addr == `INPC_FAST_VEC_ADDR] <= 1'b0;
    end
  end

  // ==========================================================================
  // assertions
  property p_ack_pulse;
    ack |=> !ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");

  property p_ack_lat;
    req && !ack |=> ack;
  endproperty
  a_ack_lat: assert property (p_ack_lat)
    else $error("no ack one cycle after request");

  property p_rst_out;
    $fell(rst) |-> !ack && !irq && !fiq && rdata == 32'h0;
  endproperty
  a_rst_out: assert property (p_rst_out)
    else $error("outputs not quiet after reset");

  property p_nest_rd;
    rd && addr == `INPC_NEST_CTL_ADDR |-> rdata == {30'h0, nest};
  endproperty
  a_nest_rd: assert property (p_nest_rd)
    else $error("nesting control reads wrong");

  property p_vec_fmt;
    rd && vec |-> rdata[31:23] == 9'h0 && rdata[22:7] == base && rdata[1:0] == 2'h0
      && rdata[6:2] <= 5'h1B;
  endproperty
  a_vec_fmt: assert property (p_vec_fmt)
    else $error("vector layout wrong");

  property p_isr_model;
    rd && isr && known[isr_f] |-> rdata[7:0] == cur && rdata[31:8] == 24'h0;
  endproperty
  a_isr_model: assert property (p_isr_model)
    else $error("in-service status not as cleared");

  property p_fiq_first;
    fiq && !nest[0] |-> !irq;
  endproperty
  a_fiq_first: assert property (p_fiq_first)
    else $error("normal interrupt beside fast one");

  property p_rdata_hold;
    !ack ##1 !ack |-> $stable(rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without access");
endmodule

`default_nettype wire

// >>> inpc_tb.sv
/*
  Bench: wishbone drives the core end, which drives the controller;
  read answers are checked against notes in a queue.
  Assumes both ends share one clock and the interface between them.
*/
`timescale 1ns/1ps
`default_nettype none
`include "inpc_defs.svh"

module inpc_tb;
  import inpc_pkg::*;
  logic sys_clk, rst, cyc, stb, wbwe, ack;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [1:0] m;
  inpc_word_t wdat, rdat, note;
  inpc_src_t src_req;
  inpc_ext_t ext_pin;
  inpc_word_t expq[$];
  int failures, cmp_count, cycles;
  logic [15:0] base;
  logic [2:0] la, lb, lc;

  inpc_if bus ();
  inpc_device i_inpc_device (.sys_clk(sys_clk), .rst(rst), .core(bus), .src_req(src_req),
    .ext_pin(ext_pin));
  inpc_host i_inpc_host (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(wbwe), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat),
    .wb_ack_o(ack), .core(bus));
  inpc_chk i_inpc_chk (.sys_clk(sys_clk), .rst(rst), .req(bus.req), .we(bus.we),
    .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata), .ack(bus.ack), .irq(bus.irq),
    .fiq(bus.fiq));

  // ==========================================================================
  // clock, guard and verdict
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // hang guard, well above the several hundred cycles the tests take
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end

  // watcher: oldest note against each wishbone read answer
  always @(negedge sys_clk) begin
    if (ack && !wbwe) begin
      note = expq.size() > 0 ? expq.pop_front() : 'x;
      cmp_count++;
      if (note !== rdat) begin
        failures++;
        $display("MISMATCH t=%0t exp=%h got=%h", $time, note, rdat);
      end
    end
  end

  // ==========================================================================
  // bus tasks; ack is taken at the rising edge that ends the wait
  task automatic wb(input logic w, input logic [7:0] a, input inpc_word_t d);
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    wbwe <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do begin
      @(posedge sys_clk);
    end while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic dev(input logic w, input inpc_word_t a, input inpc_word_t d);
    int n;
    wb(1'b1, `INPC_HOST_ADDR_OFS, a);
    wb(1'b1, `INPC_HOST_WDATA_OFS, d);
    wb(1'b1, `INPC_HOST_CTRL_OFS, {30'h0, w, 1'b1});
    n = 0;
    while (bus.ack !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    if (n == 20) begin
      failures++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, 1'b1, bus.ack);
    end
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic wr(input inpc_word_t a, input inpc_word_t d);
    dev(1'b1, a, d);
  endtask

  task automatic rd(input inpc_word_t a, input inpc_word_t e);
    dev(1'b0, a, 32'h0);
    expq.push_back(e);
    wb(1'b0, `INPC_HOST_RDATA_OFS, 32'h0);
  endtask

  // status word: bit2 fast line, bit1 normal line, busy expected clear
  task automatic st(input logic f, input logic i);
    expq.push_back({29'h0, f, i, 1'b0});
    wb(1'b0, `INPC_HOST_STATUS_OFS, 32'h0);
  endtask

  function automatic inpc_word_t vec(input logic [4:0] s);
    return {9'h0, base, s, 2'h0};
  endfunction

  // ==========================================================================
  // main sequence
  initial begin
    {rst, cyc, stb, wbwe, adr, wdat, sel} = {1'b1, 47'h0};
    src_req = '0;
    ext_pin = '0;
    {failures, cmp_count, cycles} = '0;
    void'($urandom(32'h174C18CD));
    la = 3'($urandom_range(6, 0));
    lb = 3'($urandom_range(7, la + 1));
    lc = 3'($urandom_range(7, 0));
    base = 16'($urandom);
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd(`INPC_NEST_CTL_ADDR, 32'h0);
    rd(`INPC_NORMAL_ISR_ADDR, 32'h0);
    rd(`INPC_FAST_ISR_ADDR, 32'h0);
    rd(`INPC_NORMAL_VEC_ADDR, 32'h0);
    st(1'b0, 1'b0);
    $display("reset values done");
    // normal nesting: higher level lb served first, lower level la nests over it
    wr(`INPC_VEC_BASE_ADDR, {16'h0, base});
    wr(`INPC_PRIO0_ADDR, {9'h0, lb, 9'h0, lc, 1'h0, la, 4'h0});
    wr(`INPC_NEST_CTL_ADDR, 32'h1);
    wr(`INPC_NORMAL_EN_ADDR, 32'h22);
    src_req[5] <= 1'b1;
    st(1'b0, 1'b1);
    rd(`INPC_NORMAL_VEC_ADDR, vec(5'h05));
    rd(`INPC_NORMAL_ISR_ADDR, 32'h1 << lb);
    st(1'b0, 1'b0);
    src_req[1] <= 1'b1;
    st(1'b0, 1'b1);
    rd(`INPC_NORMAL_VEC_ADDR, vec(5'h01));
    rd(`INPC_NORMAL_ISR_ADDR, (32'h1 << la) | (32'h1 << lb));
    for (int i = 0; i < 3; i++) begin
      wr(`INPC_NORMAL_ISR_ADDR, $urandom & 32'hFF);
      rd(`INPC_NORMAL_ISR_ADDR, i == 0 ? 32'h1 << lb : 32'h0);
    end
    $display("normal nesting done");
    // fast nesting, then both nest bits off with both types pending
    src_req[1] <= 1'b0;
    wr(`INPC_NEST_CTL_ADDR, 32'h3);
    wr(`INPC_FAST_EN_ADDR, 32'h4);
    src_req[2] <= 1'b1;
    st(1'b1, 1'b1);
    rd(`INPC_FAST_VEC_ADDR, vec(5'h02));
    rd(`INPC_FAST_ISR_ADDR, 32'h1 << lc);
    wr(`INPC_FAST_ISR_ADDR, 32'hFF);
    rd(`INPC_FAST_ISR_ADDR, 32'h0);
    wr(`INPC_NEST_CTL_ADDR, 32'h0);
    st(1'b1, 1'b0);
    src_req[2] <= 1'b0;
    st(1'b0, 1'b1);
    $display("fast nesting done");
    // external lines, every trigger code; pins parked at their idle level
    src_req <= '0;
    for (int k = 0; k < 6; k++) begin
      m = 2'(k + 2);
      ext_pin[k] <= m[0];
      wr(`INPC_NORMAL_EN_ADDR, 32'h1 << (17 + k));
      wr(`INPC_TRIG_CFG_ADDR, inpc_word_t'(m) << (2 * k));
      st(1'b0, 1'b0);
      ext_pin[k] <= !m[0];
      @(posedge sys_clk); // edge latch adds a cycle
      st(1'b0, 1'b1);
      ext_pin[k] <= m[0];
      st(1'b0, m[1]);
      wr(`INPC_EDGE_CLR_ADDR, 32'h1 << (k < 4 ? 19 + k : 20 + k));
      st(1'b0, 1'b0);
    end
    $display("external lines done");
    summarize();
  end
endmodule

`default_nettype wire
